// ---- iwd_defines.vh ----
/*
 Constants for the independent watchdog: option word field layout,
 register map, timing and state codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef IWD_DEFINES_VH
`define IWD_DEFINES_VH

// ----------------------------------------------------------------
// Option word field positions
// ----------------------------------------------------------------
`define IWD_OPT_START_BIT      1
`define IWD_OPT_TOPS_LSB       2
`define IWD_OPT_TOPS_MSB       3
`define IWD_OPT_CKS_LSB        4
`define IWD_OPT_CKS_MSB        7
`define IWD_OPT_RPES_LSB       8
`define IWD_OPT_RPES_MSB       9
`define IWD_OPT_RPSS_LSB       10
`define IWD_OPT_RPSS_MSB       11
`define IWD_OPT_RSTIRQ_BIT     12
`define IWD_OPT_STPCTL_BIT     14
`define IWD_OPT_HALF_MSB       15

// ----------------------------------------------------------------
// Register byte addresses (word aligned, 4-bit byte address)
// ----------------------------------------------------------------
`define IWD_ADDR_W             4
`define IWD_ADR_OPTION         4'h0
`define IWD_ADR_REFRESH        4'h4
`define IWD_ADR_STATUS         4'h8
`define IWD_ADR_COUNT          4'hC

// Refresh needs 00h then FFh, so a stray single write never refreshes
`define IWD_KEY_FIRST          8'h00
`define IWD_KEY_SECOND         8'hFF

// Status register bit positions
`define IWD_ST_UNDER_BIT       0
`define IWD_ST_WINERR_BIT      1
`define IWD_ST_RSTCAUSE_BIT    2
`define IWD_ST_RUN_BIT         3

// ----------------------------------------------------------------
// Counter and timing
// ----------------------------------------------------------------
`define IWD_CNT_W              14
`define IWD_PRE_W              8
`define IWD_RESET_PULSE_NS     100
`define IWD_CLK_NS             5
`define IWD_RESET_PULSE_CYC    ((`IWD_RESET_PULSE_NS + `IWD_CLK_NS - 1) / `IWD_CLK_NS)
`define IWD_PULSE_W            6

// ----------------------------------------------------------------
// One-hot states of the watchdog sequencer
// ----------------------------------------------------------------
`define IWD_ST_W               4
`define IWD_S_IDLE             4'h1
`define IWD_S_RUN              4'h2
`define IWD_S_RESET            4'h4
`define IWD_S_NMI              4'h8

`endif

// ---- iwd_prescaler.v ----
/*
 Clock divisor for the watchdog counter: turns the dedicated clock
 (sampled as a pin) into a one-cycle count tick.
 Assumes wdog_clk_tick marks one dedicated clock rising edge.
*/
`timescale 1ns/1ps
`include "iwd_defines.vh"

module iwd_prescaler (
   input  wire                   core_clk,       // System clock
   input  wire                   reset_n,        // Async reset, active low
   input  wire                   clear,          // Restart the divisor phase
   input  wire                   wdog_clk_tick,  // One dedicated clock edge
   input  wire [3:0]             wdog_clock_divisor, // Divisor select code
   output reg                    count_tick      // Tick for the counter
);

   reg [`IWD_PRE_W-1:0]          pre_r;          // Edge counter
   reg [`IWD_PRE_W-1:0]          pre_nxt;
   reg [`IWD_PRE_W-1:0]          limit;          // Edges per tick minus one

   // ---------------------------------------------------------------
   // Divisor decode: 1, 16, 32, 64, 128, 256; other codes act as 1
   // ---------------------------------------------------------------
   always @* begin
      case (wdog_clock_divisor)
         4'h2:    limit = 8'h0F;
         4'h3:    limit = 8'h1F;
         4'h4:    limit = 8'h3F;
         4'hF:    limit = 8'h7F;
         4'h5:    limit = 8'hFF;
         default: limit = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Divide edges; a tick fires on the last edge of each group
   // ---------------------------------------------------------------
   always @* begin
      pre_nxt = pre_r;
      if (clear) begin
         pre_nxt = 8'h00;
      end else if (wdog_clk_tick) begin
         pre_nxt = (pre_r >= limit) ? 8'h00 : pre_r + 8'h01;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_r      <= 8'h00;
         count_tick <= 1'b0;
      end else begin
         pre_r      <= pre_nxt;
         count_tick <= ~clear & wdog_clk_tick & (pre_r >= limit);
      end
   end

endmodule // iwd_prescaler

// ---- iwd_watchdog.v ----
/*
 Independent watchdog with option-word configuration and an
 Avalon-MM slave with waitrequest for software access.
 Assumes the option word is stable once reset_n goes high, the
 dedicated clock is slow against core_clk, and the reset-cause flag
 sits in a domain that the chip reset it requests does not clear.
*/
// Added by the designer: the placing of the registers and the Avalon-MM register port.
// Summary of operation
// - Unrefreshed counter times out, resets chip
// - Refresh outside window counts as error
// - Interrupt mode raises NMI instead of reset
// - Reset mode resets on underflow or window
// - Readable flag shows watchdog caused reset
// - Config from 32-bit option word, low half
// - Auto-start bit1, timeout 3:2, divisor 7:4
// - Window end/start fields; 0%/100% disable
// - Bit 12 reset/NMI, bit 14 standby stop
`timescale 1ns/1ps
`include "iwd_defines.vh"

module iwd_watchdog (
   input  wire                   core_clk,          // System clock, 200 MHz
   input  wire                   reset_n,           // Async reset, active low
   input  wire [31:0]            option_word,       // User-programmed option word
   input  wire                   wdog_clk,          // Dedicated clock, as a pin
   input  wire                   standby,           // Low-power standby request
   input  wire                   cause_clear_n,     // Power-on reset of cause flag
   input  wire [`IWD_ADDR_W-1:0] avs_address,       // Byte address
   input  wire                   avs_read,          // Read strobe
   input  wire                   avs_write,         // Write strobe
   input  wire [31:0]            avs_writedata,     // Write data
   input  wire [3:0]             avs_byteenable,    // Byte lanes
   output reg  [31:0]            avs_readdata,      // Read data
   output reg                    avs_waitrequest,   // Hold-off
   output reg                    chip_reset_req,    // Chip reset request
   output reg                    nmi_req,           // Non-maskable interrupt
   output reg                    wdog_reset_cause   // Last reset was watchdog
);

   // ---------------------------------------------------------------
   // Option word capture
   // ---------------------------------------------------------------
   reg  [15:0]                   opt_r;             // Latched low half-word
   reg                           opt_done_r;        // Capture has happened

   wire                          wdog_auto_start           = opt_r[`IWD_OPT_START_BIT];
   wire [1:0]                    wdog_timeout_select       = opt_r[`IWD_OPT_TOPS_MSB:`IWD_OPT_TOPS_LSB];
   wire [3:0]                    wdog_clock_divisor        = opt_r[`IWD_OPT_CKS_MSB:`IWD_OPT_CKS_LSB];
   wire [1:0]                    wdog_window_end           = opt_r[`IWD_OPT_RPES_MSB:`IWD_OPT_RPES_LSB];
   wire [1:0]                    wdog_window_start         = opt_r[`IWD_OPT_RPSS_MSB:`IWD_OPT_RPSS_LSB];
   wire                          wdog_reset_or_irq_select  = opt_r[`IWD_OPT_RSTIRQ_BIT];
   wire                          wdog_standby_stop_control = opt_r[`IWD_OPT_STPCTL_BIT];

   // Capture after release; async reset may only load constants
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         opt_r      <= 16'h0000;
         opt_done_r <= 1'b0;
      end else if (!opt_done_r) begin
         opt_r      <= option_word[`IWD_OPT_HALF_MSB:0];
         opt_done_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Dedicated clock synchroniser, three stages
   // ---------------------------------------------------------------
   reg                           wclk_s1_r;         // Metastable stage
   reg                           wclk_s2_r;
   reg                           wclk_s3_r;
   reg                           wclk_lvl_r;        // Filtered level
   wire                          wclk_rise = (wclk_s2_r == wclk_s3_r) & wclk_s2_r & ~wclk_lvl_r;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wclk_s1_r  <= 1'b0;
         wclk_s2_r  <= 1'b0;
         wclk_s3_r  <= 1'b0;
         wclk_lvl_r <= 1'b0;
      end else begin
         wclk_s1_r <= wdog_clk;
         wclk_s2_r <= wclk_s1_r;
         wclk_s3_r <= wclk_s2_r;
         if (wclk_s2_r == wclk_s3_r) begin
            wclk_lvl_r <= wclk_s2_r;
         end
      end
   end

   // Standby arrives from outside the clock domain too
   reg                           stby_s1_r;
   reg                           stby_s2_r;
   reg                           stby_s3_r;
   reg                           stby_lvl_r;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stby_s1_r  <= 1'b0;
         stby_s2_r  <= 1'b0;
         stby_s3_r  <= 1'b0;
         stby_lvl_r <= 1'b0;
      end else begin
         stby_s1_r <= standby;
         stby_s2_r <= stby_s1_r;
         stby_s3_r <= stby_s2_r;
         if (stby_s2_r == stby_s3_r) begin
            stby_lvl_r <= stby_s2_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer, counter and window
   // ---------------------------------------------------------------
   reg  [`IWD_ST_W-1:0]          state_r;
   reg  [`IWD_ST_W-1:0]          state_nxt;
   reg  [`IWD_CNT_W-1:0]         cnt_r;             // Down counter
   reg  [`IWD_CNT_W-1:0]         cnt_nxt;
   reg  [`IWD_PULSE_W-1:0]       pulse_r;           // Reset pulse length
   reg                           key_armed_r;       // First key seen
   reg                           under_flag_r;      // Sticky underflow
   reg                           winerr_flag_r;     // Sticky window error
   wire                          count_tick;
   wire                          running  = (state_r == `IWD_S_RUN);
   // Stop counting in standby only when the option asks for it
   wire                          halt     = stby_lvl_r & wdog_standby_stop_control;

   // Timeout length in counts: 128, 512, 1024, 2048
   function [`IWD_CNT_W-1:0] tmo_count;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    tmo_count = 14'h007F;
            2'h1:    tmo_count = 14'h01FF;
            2'h2:    tmo_count = 14'h03FF;
            default: tmo_count = 14'h07FF;
         endcase
      end
   endfunction

   // Window position as a count: 75%, 50%, 25%, 0%/100% of period
   function [`IWD_CNT_W-1:0] win_pos;
      input [1:0]             code;
      input [`IWD_CNT_W-1:0]  full;
      begin
         case (code)
            2'h0:    win_pos = full - (full >> 2);
            2'h1:    win_pos = full >> 1;
            2'h2:    win_pos = full >> 2;
            default: win_pos = 14'h0000;
         endcase
      end
   endfunction

   wire [`IWD_CNT_W-1:0]         tmo_full  = tmo_count(wdog_timeout_select);
   // End code 3 means 0% (no end); start code 3 means 100% (no start)
   wire [`IWD_CNT_W-1:0]         win_end   = win_pos(wdog_window_end, tmo_full);
   wire [`IWD_CNT_W-1:0]         win_begin = (wdog_window_start == 2'h3) ? tmo_full :
                                             win_pos(wdog_window_start, tmo_full);
   // Refresh allowed while counter lies between start and end marks
   wire                          in_window = (cnt_r <= win_begin) & (cnt_r >= win_end);

   // Refresh register write decode, low byte lane required
   wire                          wr_refresh = avs_write & ~avs_waitrequest &
                                              (avs_address == `IWD_ADR_REFRESH) &
                                              avs_byteenable[0];
   wire                          wr_status  = avs_write & ~avs_waitrequest &
                                              (avs_address == `IWD_ADR_STATUS) &
                                              avs_byteenable[0];
   wire                          refresh    = wr_refresh & key_armed_r &
                                              (avs_writedata[7:0] == `IWD_KEY_SECOND);
   wire                          good_ref   = refresh & in_window;
   wire                          bad_ref    = refresh & running & ~in_window;
   wire                          underflow  = running & count_tick & ~halt &
                                              (cnt_r == 14'h0000);
   wire                          err        = underflow | bad_ref;

   iwd_prescaler u_pre (
      .core_clk           (core_clk),
      .reset_n            (reset_n),
      .clear              (~running),
      .wdog_clk_tick      (wclk_rise),
      .wdog_clock_divisor (wdog_clock_divisor),
      .count_tick         (count_tick)
   );

   // Next state: idle until started, run, then react to an error
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         `IWD_S_IDLE: begin
            // Auto-start, or a first refresh, launches the count
            if (opt_done_r & (wdog_auto_start == 1'b0 | refresh)) begin
               state_nxt = `IWD_S_RUN;
               cnt_nxt   = tmo_full;
            end
         end
         `IWD_S_RUN: begin
            if (err) begin
               state_nxt = wdog_reset_or_irq_select ? `IWD_S_RESET : `IWD_S_NMI;
               cnt_nxt   = tmo_full;
            end else if (good_ref) begin
               cnt_nxt = tmo_full;
            end else if (count_tick & ~halt) begin
               cnt_nxt = cnt_r - 14'h0001;
            end
         end
         `IWD_S_RESET: begin
            state_nxt = `IWD_S_RESET;
         end
         `IWD_S_NMI: begin
            // Counting resumes so a second miss is caught too
            state_nxt = `IWD_S_RUN;
         end
         default: state_nxt = `IWD_S_IDLE;
      endcase
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r        <= `IWD_S_IDLE;
         cnt_r          <= 14'h0000;
         pulse_r        <= 6'h00;
         chip_reset_req <= 1'b0;
         nmi_req        <= 1'b0;
         key_armed_r    <= 1'b0;
         under_flag_r   <= 1'b0;
         winerr_flag_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         // Two-write key sequence; any other refresh register write disarms
         if (wr_refresh) begin
            key_armed_r <= (avs_writedata[7:0] == `IWD_KEY_FIRST);
         end
         // Reset request held a fixed time then waits for chip reset
         if (state_r == `IWD_S_RESET && pulse_r != `IWD_RESET_PULSE_CYC) begin
            pulse_r        <= pulse_r + 6'h01;
            chip_reset_req <= 1'b1;
         end else begin
            chip_reset_req <= 1'b0;
         end
         nmi_req <= (state_nxt == `IWD_S_NMI);
         // Sticky flags: set beats a software clear in the same cycle
         if (underflow) begin
            under_flag_r <= 1'b1;
         end else if (wr_status & avs_writedata[`IWD_ST_UNDER_BIT]) begin
            under_flag_r <= 1'b0;
         end
         if (bad_ref) begin
            winerr_flag_r <= 1'b1;
         end else if (wr_status & avs_writedata[`IWD_ST_WINERR_BIT]) begin
            winerr_flag_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reset cause, cleared by its own power-on reset or a software write of status bit 2
   // ---------------------------------------------------------------
   always @(posedge core_clk or negedge cause_clear_n) begin
      if (!cause_clear_n) begin
         wdog_reset_cause <= 1'b0;
      end else if (state_r == `IWD_S_RESET) begin
         wdog_reset_cause <= 1'b1;
      end else if (wr_status & avs_writedata[`IWD_ST_RSTCAUSE_BIT]) begin
         wdog_reset_cause <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, answer on the second edge
   // ---------------------------------------------------------------
   reg  [31:0]                   rd_mux;

   always @* begin
      case (avs_address)
         `IWD_ADR_OPTION:  rd_mux = {16'h0000, opt_r};
         `IWD_ADR_STATUS:  rd_mux = {28'h0000000, running, wdog_reset_cause,
                                     winerr_flag_r, under_flag_r};
         `IWD_ADR_COUNT:   rd_mux = {18'h00000, cnt_r};
         default:          rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         // Drop waitrequest for one cycle per request, then re-arm
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

endmodule // iwd_watchdog

// ---- iwd_watchdog_properties.sv ----
/*
 Port-level checks on the independent watchdog, bound to iwd_watchdog.
 Assumes option_word changes only while reset_n is low.
*/
`timescale 1ns/1ps
`include "iwd_defines.vh"

module iwd_checker (
   input wire                   core_clk,
   input wire                   reset_n,
   input wire [31:0]            option_word,
   input wire                   cause_clear_n,
   input wire [`IWD_ADDR_W-1:0] avs_address,
   input wire                   avs_read,
   input wire                   avs_write,
   input wire [31:0]            avs_readdata,
   input wire                   avs_waitrequest,
   input wire                   chip_reset_req,
   input wire                   nmi_req,
   input wire                   wdog_reset_cause
);
   // ----------------------------------------------------------------
   // Helper: length of the current chip reset request
   // ----------------------------------------------------------------
   reg [5:0] rst_len_r; // Cycles the request has been high so far
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         rst_len_r <= 6'h00;
      else if (chip_reset_req)
         rst_len_r <= rst_len_r + 6'h01;
      else
         rst_len_r <= 6'h00;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Bus handshake and read values
   // ----------------------------------------------------------------
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_option_read: assert property (avs_read && !avs_waitrequest && avs_address == `IWD_ADR_OPTION
      |-> avs_readdata == {16'h0000, option_word[15:0]})
      else $error("option readback wrong");
   a_unmapped_read: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");

   // ----------------------------------------------------------------
   // Error responses and the reset cause flag
   // ----------------------------------------------------------------
   a_nmi_pulse: assert property (nmi_req |=> !nmi_req)
      else $error("interrupt request longer than one cycle");
   a_nmi_mode: assert property (nmi_req |-> !option_word[`IWD_OPT_RSTIRQ_BIT])
      else $error("interrupt raised in reset mode");
   a_reset_mode: assert property (chip_reset_req |-> option_word[`IWD_OPT_RSTIRQ_BIT])
      else $error("chip reset raised in interrupt mode");
   a_reset_len: assert property ($fell(chip_reset_req) |-> rst_len_r == 6'h14)
      else $error("chip reset request not 20 cycles");
   a_cause_set: assert property ($rose(chip_reset_req) |-> ##[0:2] wdog_reset_cause)
      else $error("reset cause not recorded");
   a_cause_keep: assert property ($fell(wdog_reset_cause)
      |-> !cause_clear_n || !$past(cause_clear_n) || $past(avs_write))
      else $error("reset cause lost without a clear");
endmodule // iwd_checker

bind iwd_watchdog iwd_checker iwd_checker_i (.*);

// ---- iwd_watchdog_test.sv ----
/*
 Self-checking bench for the independent watchdog, with a small model.
 Assumes each bus request is answered one cycle after it is taken.
*/
`timescale 1ns/1ps
`include "iwd_defines.vh"

module iwd_watchdog_test;
   localparam int WP = 16;          // Core cycles per dedicated clock period
   localparam logic [3:0] AS = `IWD_ADR_STATUS, AC = `IWD_ADR_COUNT;
   logic        core_clk, reset_n, wdog_clk, standby, cause_clear_n;
   logic [31:0] option_word;        // Option word under test
   logic [3:0]  avs_address;        // Bus address
   logic        avs_read, avs_write;
   logic [31:0] avs_writedata, avs_readdata, opt, q, c0, c1;
   logic [3:0]  avs_byteenable;
   logic        avs_waitrequest, chip_reset_req, nmi_req, wdog_reset_cause;
   logic [2:0]  wdiv;               // Dedicated clock divider
   int          err_count, check_count, nmi_cnt, cyc, i, n, t;
   int          cks_tab[6] = '{0, 2, 3, 4, 15, 5};
   int          end_pct[4] = '{75, 50, 25, 0};
   int          beg_pct[4] = '{75, 50, 25, 100};

   iwd_watchdog iwd_watchdog_i (.*);

   // ----------------------------------------------------------------
   // Clocks and monitors
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Dedicated clock kept slow, as the synchronisers need
   always @(posedge core_clk) begin
      wdiv <= wdiv + 3'h1;
      if (wdiv == 3'h7)
         wdog_clk <= ~wdog_clk;
      cyc <= cyc + 1;
      if (nmi_req === 1'b1)
         nmi_cnt <= nmi_cnt + 1;
   end

   // ----------------------------------------------------------------
   // Model: code tables and window test
   // ----------------------------------------------------------------
   function automatic int tout(input int c);
      return 128 << ((c == 0) ? 0 : c + 1);
   endfunction
   function automatic int cdiv(input int c);
      case (c)
         2: return 16;
         3: return 32;
         4: return 64;
         5: return 256;
         15: return 128;
         default: return 1;
      endcase
   endfunction
   function automatic bit inwin(input int cnt, input int full, input int e, input int s);
      return (cnt * 100 <= beg_pct[s] * full) && (cnt * 100 >= end_pct[e] * full);
   endfunction
   // Upper half random: the block must ignore it
   function automatic logic [31:0] mk(input int aoff, tops, cks, e, s, rst, stp);
      return {$urandom, 16'h0} | (stp << 14) | (rst << 12) | (s << 10) | (e << 8)
         | (cks << 4) | (tops << 2) | (aoff << 1);
   endfunction

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cy(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // One bus cycle; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      cy(1);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         cy(1);
         k++;
      end
      if (k == 50)
         err_count++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      cy(1);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      bus(1'b0, a, 32'h0, v);
   endtask
   task automatic refresh();
      bus(1'b1, `IWD_ADR_REFRESH, 32'h0, q);
      bus(1'b1, `IWD_ADR_REFRESH, 32'hFF, q);
   endtask
   task automatic do_reset(input logic [31:0] o);
      reset_n <= 1'b0;
      option_word <= o;
      cy(4);
      reset_n <= 1'b1;
      cy(2);
   endtask
   // Bounded wait for a chip reset request
   task automatic wait_err(input int lim);
      n = 0;
      while (chip_reset_req !== 1'b1 && n < lim) begin
         cy(1);
         n++;
      end
   endtask
   task finish_test;
      $display("TB: checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard, about one and a half times the expected run
   initial begin
      #300000;
      err_count++;
      finish_test;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {reset_n, cause_clear_n, wdog_clk, standby, avs_read, avs_write} = 6'h00;
      {avs_address, avs_writedata, option_word, wdiv} = 0;
      avs_byteenable = 4'hF;
      {err_count, check_count, nmi_cnt, cyc} = 0;
      void'($urandom(39638));
      cy(4);
      cause_clear_n <= 1'b1;
      // Load value and count rate for each timeout and divisor code
      for (i = 0; i < 6; i++) begin
         opt = mk(0, i % 4, cks_tab[i], 3, 3, 0, 0);
         do_reset(opt);
         bus(1'b1, `IWD_ADR_OPTION, $urandom, q);
         rd(`IWD_ADR_OPTION, q);
         chk("option", q, {16'h0000, opt[15:0]});
         rd(4'h6, q);
         chk("unmapped", q, 32'h0);
         rd(AS, q);
         chk("running", q[3], 1);
         rd(AC, c0);
         chk("load", c0 <= tout(i % 4) - 1 && c0 + 3 >= tout(i % 4) - 1, 1);
         cy(3 * cdiv(cks_tab[i]) * WP);
         rd(AC, c1);
         chk("rate", c0 - c1 >= 2 && c0 - c1 <= 4, 1);
      end
      // Start by refresh, interrupt response, broken key sequence
      do_reset(mk(1, 0, 0, 3, 3, 0, 0));
      cy(20 * WP);
      rd(AS, q);
      chk("stopped", q[3], 0);
      nmi_cnt = 0;
      for (i = 0; i < 4; i++) begin
         refresh();
         rd(AC, c0);
         chk("reload", c0 + 3 >= 127, 1);
         cy(100 * WP);
      end
      chk("no_nmi", nmi_cnt, 0);
      refresh();
      t = cyc;
      cy(40 * WP);
      bus(1'b1, `IWD_ADR_REFRESH, 32'h0, q);
      bus(1'b1, `IWD_ADR_REFRESH, 32'h55, q);
      bus(1'b1, `IWD_ADR_REFRESH, 32'hFF, q);
      n = 0;
      while (nmi_cnt == 0 && n < 200 * WP) begin
         cy(1);
         n++;
      end
      chk("nmi_time", cyc - t >= 126 * WP && cyc - t <= 131 * WP, 1);
      chk("no_chip_reset", chip_reset_req, 0);
      rd(AS, q);
      chk("underflow", q[0], 1);
      bus(1'b1, AS, 32'h1, q);
      rd(AS, q);
      chk("underflow_clr", q[0], 0);
      cy(135 * WP);
      chk("nmi_again", nmi_cnt, 2);
      // Reset response: early refresh, cause flag, late refresh
      opt = mk(0, 0, 0, 3, 1, 1, 0);
      do_reset(opt);
      rd(AC, c0);
      refresh();
      wait_err(20);
      chk("early", chip_reset_req, !inwin(c0, 128, 3, 1));
      rd(AS, q);
      chk("win_err", q[1], 1);
      chk("cause", wdog_reset_cause, 1);
      cy(30);
      do_reset(opt);
      chk("cause_kept", wdog_reset_cause, 1);
      rd(AS, q);
      chk("cause_bit", q[2], 1);
      bus(1'b1, AS, 32'h4, q);
      rd(AS, q);
      chk("cause_clr", q[2], 0);
      t = 10 + $urandom % 40;
      c0 = 32'hFFFF;
      for (n = 0; n < 400 && c0 > t; n++)
         rd(AC, c0);
      refresh();
      cy(6);
      chk("in_window", chip_reset_req, !inwin(c0, 128, 3, 1));
      wait_err(140 * WP);
      chk("timeout", chip_reset_req, 1);
      cy(30);
      cause_clear_n <= 1'b0;
      cy(2);
      chk("cause_por", wdog_reset_cause, 0);
      cause_clear_n <= 1'b1;
      // Standby halts counting only when stop control is set
      for (i = 0; i < 2; i++) begin
         do_reset(mk(0, 1, 0, 3, 3, 0, i));
         standby <= 1'b1;
         cy(8);
         rd(AC, c0);
         cy(10 * WP);
         rd(AC, c1);
         chk("standby", c0 - c1 >= 9, i == 0);
         standby <= 1'b0;
      end
      finish_test;
   end
endmodule // iwd_watchdog_test
